/* hdl/rst_init_pkg.sv */
/*
 Shared constants for the reset and init distribution block.
 Assumes a single 125 MHz clock domain.
*/
package rst_init_pkg;
    // Clock rate and timing
    localparam int CLK_MHZ = 125;
    localparam int CORE_PULSE_NS = 80;
    localparam int CORE_PULSE_CYC = (CORE_PULSE_NS * CLK_MHZ + 999) / 1000;
    // Interrupt mode select values
    localparam logic MODE_DIRECT = 1'b0;
    localparam logic MODE_THRU_UNIT = 1'b1;
    localparam logic [7:0] MODE_SEL_THRU = 8'h01;
    // Reset synchroniser depth
    localparam int SYNC_STAGES = 2;
    // Init message delivery mode code for reset delivery
    localparam logic [2:0] DELIV_RESET = 3'h5;
    // Vector of fpu irq line index
    localparam int FPU_IRQ_NUM = 13;
endpackage

/* hdl/core_init_if.sv */
/*
 Interface carrying per-core init requests from the top to pulse units.
 Assumes the clock domain of the top module.
*/
`timescale 1ns/1ps
interface core_init_if;
    logic fire; // One-cycle request to start a pulse
    logic hard; // System hard reset held
    logic busy; // Pulse in progress
    modport src (output fire, output hard, input busy);
    modport dst (input fire, input hard, output busy);
endinterface

/* hdl/core_pulse.sv */
/*
 One core reset pulse generator: asserts for a fixed count then releases.
 Assumes fire is a synchronous one-cycle pulse.
*/
`timescale 1ns/1ps
module core_pulse
    import rst_init_pkg::*;
#(
    parameter int WIDTH = CORE_PULSE_CYC
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Synchronised reset, active low
    core_init_if.dst ctl, // Request from top
    output logic pulse // Core reset out
);
    initial begin
        if (WIDTH < 1 || WIDTH > 65535)
            $error("WIDTH must fit the 16-bit counter");
    end
    logic [15:0] count; // Cycles remaining
    // ==========================================================
    // Pulse counter
    // Hard reset forces the output until released
    always_ff @(posedge clk) begin
        if (!rstn || ctl.hard) begin
            count <= '0;
            pulse <= 1'b1;
        end else if (ctl.fire && count == '0) begin
            count <= 16'(WIDTH);
            pulse <= 1'b1;
        end else if (count > 16'h0001) begin
            count <= count - 16'h0001;
        end else begin
            count <= '0;
            pulse <= 1'b0;
        end
    end
    assign ctl.busy = (count != '0);
endmodule

/* hdl/mp_reset_init_distribution.sv */
/*
 Reset and init distribution for a multiprocessor platform: hard reset,
 system init, per-core init messages, mode select and boot routing.
 Assumes all inputs synchronous to clk except rstn and panel_reset.
*/
// Overview of operation
// - Hard reset reaches every component
// - Hard reset acts immediately
// - Soft init waits for cycle boundary
// - Soft init spares caches and FPU
// - Reset port write raises soft init
// - Shutdown cycle raises soft init
// - Reset and init reach all processors
// - Fault-tolerant: per-processor soft init
// - Software triggers per-processor init
// - Init message pulses target core reset
// - Pulse restarts processor at reset vector
// - Core reset solely drives processor reset
// - Hard reset makes all units pulse
// - Integrated unit pulses internal init
// - Units disabled except boot virtual-wire
// - IO unit pending cleared, inputs disabled
// - Mode select starts zero
// - Application processors real mode, halted
// - Interrupt lines go to boot processor
// - Boot processor FPU error makes FPU_IRQ_LINE
// - Boot processor masks address bit 20
// - Mode select clears on reset/init
// - Writing one routes through unit
`timescale 1ns/1ps
module mp_reset_init_distribution
    import rst_init_pkg::*;
#(
    parameter int NCPU = 4,
    parameter int PULSE_CYC = CORE_PULSE_CYC,
    parameter int ID_W = 2,
    parameter bit FAULT_TOL = 1'b0
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Power-on reset, active low
    input wire logic panel_reset, // Front-panel reset request
    input wire logic reset_port_wr, // Reset port write strobe
    input wire logic shutdown_cycle, // Shutdown special cycle seen
    input wire logic cycle_boundary, // Bus at a cycle boundary
    input wire logic [NCPU-1:0] init_select, // Per-cpu soft init mask
    input wire logic ipi_valid, // Init message strobe
    input wire logic [2:0] ipi_mode, // Delivery mode
    input wire logic [NCPU-1:0] ipi_dest, // Destination mask
    input wire logic mode_wr, // Mode select write strobe
    input wire logic [7:0] mode_wdata, // Mode select data
    input wire logic start_virtual_wire, // Startup in virtual-wire mode
    input wire logic [ID_W-1:0] boot_id, // Designated boot processor
    input wire logic nmi_in, // Nonmaskable request
    input wire logic maskable_request, // Legacy maskable request
    input wire logic [NCPU-1:0] fpu_error_out, // Per-cpu FPU error
    input wire logic addr20_gate, // System address 20 gate
    output logic hard_reset, // System hard reset to all
    output logic [NCPU-1:0] core_reset_out, // Per-core reset/init
    output logic [NCPU-1:0] soft_init, // Soft init per cpu
    output logic [NCPU-1:0] unit_enable, // Local unit enables
    output logic io_unit_clear, // Clears IO unit state
    output logic interrupt_mode_select_reg, // Mode select state
    output logic [NCPU-1:0] nmi_out, // Direct NMI per cpu
    output logic [NCPU-1:0] maskable_out, // Direct maskable per cpu
    output logic [NCPU-1:0] lint_nmi, // NMI through local unit
    output logic [NCPU-1:0] lint_maskable, // Maskable through unit
    output logic [NCPU-1:0] ignore_fpu_error_in, // Ignore error per cpu
    output logic [NCPU-1:0] addr_bit20_mask_in, // A20 mask per cpu
    output logic fpu_irq_line, // Interrupt line 13
    output logic [NCPU-1:0] ap_hold // Hold APs halted
);
    initial begin
        if (NCPU < 1 || NCPU > (1 << ID_W))
            $error("NCPU does not fit boot id width");
        if (PULSE_CYC < 1 || PULSE_CYC > 65535)
            $error("PULSE_CYC must fit the 16-bit hold counter");
    end

    // ==========================================================
    // Hard reset: combinational assertion, synchronised release
    logic [SYNC_STAGES-1:0] rel_sync; // Release shift chain
    logic hard_req; // Raw hard request
    logic sys_rstn; // Synchronised internal reset
    assign hard_req = !rstn || panel_reset;
    // Assertion bypasses the clock so no cycle can delay it
    assign hard_reset = hard_req || !rel_sync[SYNC_STAGES-1];
    assign sys_rstn = rel_sync[SYNC_STAGES-1];
    // Release walks through the chain before internal logic runs
    always_ff @(posedge clk) begin
        if (hard_req) begin
            rel_sync <= '0;
        end else begin
            rel_sync <= {rel_sync[SYNC_STAGES-2:0], 1'b1};
        end
    end

    // ==========================================================
    // Soft init request capture and cycle-boundary wait
    logic soft_pend; // Request waiting for boundary
    logic soft_fire; // Soft init issued this cycle
    logic [NCPU-1:0] soft_mask; // Processors to initialise
    logic soft_busy; // Soft init currently driven
    assign soft_fire = soft_pend && cycle_boundary && !soft_busy;
    // Fault-tolerant systems may target a subset
    assign soft_mask = FAULT_TOL ? init_select : '1;
    // New requests win over the clear in the same cycle
    always_ff @(posedge clk) begin
        if (!sys_rstn) begin
            soft_pend <= 1'b0;
        end else if (reset_port_wr || shutdown_cycle) begin
            soft_pend <= 1'b1;
        end else if (soft_fire) begin
            soft_pend <= 1'b0;
        end
    end

    // ==========================================================
    // Soft init pulse; drives init only, so caches survive
    typedef enum logic [1:0] {SI_IDLE, SI_HOLD} si_state_t;
    si_state_t si_state; // Soft init state
    logic [15:0] si_count; // Hold counter
    assign soft_busy = (si_state == SI_HOLD);
    always_ff @(posedge clk) begin
        if (!sys_rstn) begin
            si_state <= SI_IDLE;
            si_count <= '0;
            soft_init <= '0;
        end else begin
            unique case (si_state)
                SI_IDLE: begin
                    if (soft_fire) begin
                        si_state <= SI_HOLD;
                        si_count <= 16'(PULSE_CYC);
                        soft_init <= soft_mask;
                    end
                end
                SI_HOLD: begin
                    if (si_count <= 16'h0001) begin
                        si_state <= SI_IDLE;
                        si_count <= '0;
                        soft_init <= '0;
                    end else begin
                        si_count <= si_count - 16'h0001;
                    end
                end
                default: begin
                    si_state <= SI_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Per-core init pulses from init messages
    logic [NCPU-1:0] pulse; // Per-unit pulse outputs
    logic msg_reset; // Message carries reset delivery
    assign msg_reset = ipi_valid && (ipi_mode == DELIV_RESET);
    generate
        for (genvar i = 0; i < NCPU; i++) begin : g_core
            core_init_if cif ();
            assign cif.fire = msg_reset && ipi_dest[i];
            assign cif.hard = !sys_rstn;
            core_pulse #(.WIDTH(PULSE_CYC)) u_pulse (
                .clk(clk),
                .rstn(sys_rstn),
                .ctl(cif),
                .pulse(pulse[i])
            );
        end
    endgenerate
    // Only the unit pulse and hard reset drive each core input,
    // so a message restarts just its target at the reset vector
    always_comb begin
        core_reset_out = pulse | {NCPU{hard_reset}};
    end

    // ==========================================================
    // Interrupt mode select register
    // Cleared by hard reset or system-wide init
    always_ff @(posedge clk) begin
        if (!sys_rstn || soft_fire) begin
            interrupt_mode_select_reg <= MODE_DIRECT;
        end else if (mode_wr) begin
            interrupt_mode_select_reg <= (mode_wdata == MODE_SEL_THRU)
                ? MODE_THRU_UNIT : MODE_DIRECT;
        end
    end

    // ==========================================================
    // Initial-state outputs
    logic [NCPU-1:0] boot_onehot; // Boot processor select
    // Unit enables are latched at release, never from a port in reset
    always_ff @(posedge clk) begin
        if (!sys_rstn) begin
            unit_enable <= '0;
            io_unit_clear <= 1'b1;
            ap_hold <= '1;
        end else begin
            io_unit_clear <= 1'b0;
            if (io_unit_clear) begin
                for (int k = 0; k < NCPU; k++) begin
                    unit_enable[k] <= start_virtual_wire
                        && (ID_W'(k) == boot_id);
                    ap_hold[k] <= (ID_W'(k) != boot_id);
                end
            end else if (msg_reset) begin
                // Init message targets other than the boot processor go back to halted real mode
                ap_hold <= ap_hold | (ipi_dest & ~boot_onehot);
            end
        end
    end

    // ==========================================================
    // Boot processor routing for fault-resilient boot
    logic thru; // Route through local unit
    assign thru = interrupt_mode_select_reg;
    always_comb begin
        boot_onehot = '0;
        for (int k = 0; k < NCPU; k++) begin
            boot_onehot[k] = (ID_W'(k) == boot_id);
        end
    end
    // Registered data outputs; the one-cycle lag is harmless here
    always_ff @(posedge clk) begin
        if (!sys_rstn) begin
            nmi_out <= '0;
            maskable_out <= '0;
            lint_nmi <= '0;
            lint_maskable <= '0;
            ignore_fpu_error_in <= '0;
            addr_bit20_mask_in <= '0;
            fpu_irq_line <= 1'b0;
        end else begin
            nmi_out <= thru ? '0 : boot_onehot & {NCPU{nmi_in}};
            maskable_out <= thru ? '0
                : boot_onehot & {NCPU{maskable_request}};
            lint_nmi <= thru ? boot_onehot & {NCPU{nmi_in}} : '0;
            lint_maskable <= thru
                ? boot_onehot & {NCPU{maskable_request}} : '0;
            // Only the boot processor's error reaches line 13
            fpu_irq_line <= |(fpu_error_out & boot_onehot);
            ignore_fpu_error_in <= boot_onehot
                & {NCPU{~(|(fpu_error_out & boot_onehot))}};
            addr_bit20_mask_in <= boot_onehot & {NCPU{~addr20_gate}};
        end
    end
endmodule

/* verif/cores_model.sv */
/*
 Behavioural model of the processor cores on the far side.
 Assumes core reset lines are synchronous to clk.
*/
`timescale 1ns/1ps
module cores_model #(
    parameter int N = 4
) (
    input wire logic clk, // System clock
    input wire logic [N-1:0] core_rst, // Reset line per core
    input wire logic clr, // Clears restart flags
    output logic [N-1:0] restarted // Core has restarted
);
    // ==========
    // Restart tracking
    logic [N-1:0] prev; // Last sampled reset lines
    // A core starts at its reset vector when its reset line falls
    always_ff @(posedge clk) begin
        prev <= core_rst;
        restarted <= clr ? '0 : restarted | (prev & ~core_rst);
    end
endmodule

/* verif/mp_reset_init_chk.sv */
/*
 Concurrent checks on the reset and init distribution block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module mp_reset_init_chk
    import rst_init_pkg::*;
#(
    parameter int NCPU = 4,
    parameter int PULSE_CYC = CORE_PULSE_CYC,
    parameter int ID_W = 2
) (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset
    input wire logic panel_reset, // Panel request
    input wire logic reset_port_wr, // Port write
    input wire logic shutdown_cycle, // Shutdown seen
    input wire logic cycle_boundary, // Boundary
    input wire logic ipi_valid, // Message strobe
    input wire logic [2:0] ipi_mode, // Delivery mode
    input wire logic [NCPU-1:0] ipi_dest, // Targets
    input wire logic mode_wr, // Mode write
    input wire logic [7:0] mode_wdata, // Mode data
    input wire logic [ID_W-1:0] boot_id, // Boot index
    input wire logic nmi_in, // NMI in
    input wire logic hard_reset, // Hard reset
    input wire logic [NCPU-1:0] core_reset_out, // Core resets
    input wire logic [NCPU-1:0] soft_init, // Soft init
    input wire logic interrupt_mode_select_reg, // Mode
    input wire logic [NCPU-1:0] nmi_out // Direct NMI
);
    // ==========
    // Helper: cycles core 0 pulse has stood, hard reset excluded
    int hi_cnt;
    always_ff @(posedge clk) begin
        if (!rstn || !core_reset_out[0] || hard_reset) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Request, then a boundary while no pulse stands
    sequence soft_req;
        (reset_port_wr || shutdown_cycle) && soft_init == 0 && !hard_reset
        ##1 cycle_boundary && soft_init == 0 && !hard_reset;
    endsequence
    sequence ipi_req;
        ipi_valid && ipi_mode == DELIV_RESET && core_reset_out == 0
        && !hard_reset;
    endsequence
    AST_HARD_NOW: assert property (panel_reset |-> hard_reset)
        else $error("hard reset lags panel request");
    AST_HARD_ALL: assert property (hard_reset |-> &core_reset_out)
        else $error("core reset missing under hard reset");
    AST_IPI_DEST: assert property (ipi_req |=>
        core_reset_out == $past(ipi_dest) || hard_reset)
        else $error("init message reached wrong cores");
    AST_PULSE_LEN: assert property ($fell(core_reset_out[0])
        && !$past(hard_reset) && !$past(hard_reset, 2)
        |-> hi_cnt == PULSE_CYC)
        else $error("core pulse length wrong");
    AST_SOFT_WAIT: assert property ($rose(soft_init[0])
        |-> $past(cycle_boundary))
        else $error("soft init off a cycle boundary");
    AST_SOFT_FIRE: assert property (soft_req |=> &soft_init)
        else $error("soft init not raised");
    AST_SOFT_ALL: assert property (soft_init != 0 |-> &soft_init)
        else $error("soft init not system wide");
    AST_MODE_CLR: assert property ($rose(soft_init[0])
        |-> !interrupt_mode_select_reg)
        else $error("mode select kept over init");
    AST_MODE_SET: assert property (mode_wr && !hard_reset
        && mode_wdata == MODE_SEL_THRU |=> interrupt_mode_select_reg
        || $rose(soft_init[0]) || hard_reset)
        else $error("mode select not set");
    AST_NMI_ROUTE: assert property (!hard_reset |=> nmi_out ==
        (NCPU'($past(nmi_in) & ~$past(interrupt_mode_select_reg))
        << $past(boot_id)))
        else $error("direct NMI misrouted");
endmodule
bind mp_reset_init_distribution mp_reset_init_chk #(.NCPU(NCPU),
    .PULSE_CYC(PULSE_CYC), .ID_W(ID_W)) chk_u (.*);

/* verif/mp_reset_init_distribution_tb.sv */
/*
 Self-checking bench for the reset and init distribution block.
 Assumes four cores, a pulse of two cycles and boot processor 2.
*/
`timescale 1ns/1ps
module mp_reset_init_distribution_tb;
    import rst_init_pkg::*;
    // ==========
    // Stimulus and observed signals
    logic clk = 1'h0, rstn = 1'h0, panel_reset = 1'h0, clr = 1'h1;
    logic reset_port_wr = 1'h0, shutdown_cycle = 1'h0, ipi_valid = 1'h0;
    logic cycle_boundary = 1'h0, mode_wr = 1'h0, nmi_in = 1'h0;
    logic start_virtual_wire = 1'h1, maskable_request = 1'h0;
    logic addr20_gate = 1'h1;
    logic [3:0] init_select = 4'h0, ipi_dest = 4'h0, fpu_error_out = 4'h0;
    logic [2:0] ipi_mode = 3'h0;
    logic [7:0] mode_wdata = 8'h00;
    logic [1:0] boot_id = 2'h2;
    logic hard_reset, io_unit_clear, interrupt_mode_select_reg;
    logic fpu_irq_line;
    logic [3:0] core_reset_out, soft_init, unit_enable, nmi_out, ap_hold;
    logic [3:0] maskable_out, lint_nmi, lint_maskable, restarted;
    logic [3:0] ignore_fpu_error_in, addr_bit20_mask_in;
    int miscompares = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    mp_reset_init_distribution #(.PULSE_CYC(2)) dut_u (.*);
    cores_model cores_u (.clk(clk), .core_rst(core_reset_out), .clr(clr),
        .restarted(restarted));
    // ==========
    // Shared compare and closing report
    task chk(input string what, input logic [3:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Startup state once reset has settled
    task t_init;
        chk("units", unit_enable, 4'h4);
        chk("hold", ap_hold, 4'hB);
        chk("ioclr", 4'(io_unit_clear), 4'h0);
        chk("mode", 4'(interrupt_mode_select_reg), 4'h0);
        chk("cores", core_reset_out, 4'h0);
        chk("fpu_irq_line", 4'(fpu_irq_line), 4'h0);
        chk("ignerr", ignore_fpu_error_in, 4'h4);
        chk("addr_bit20_mask_in", addr_bit20_mask_in, 4'h0);
    endtask
    // Lines go direct to boot cpu, then through its unit
    task t_route;
        @(posedge clk) begin
            nmi_in <= 1'h1;
            maskable_request <= 1'h1;
            mode_wr <= 1'h1;
            mode_wdata <= MODE_SEL_THRU;
        end
        @(posedge clk) mode_wr <= 1'h0;
        #1 chk("nmi", nmi_out, 4'h4);
        chk("mask", maskable_out, 4'h4);
        @(posedge clk) #1 chk("lnmi", lint_nmi, 4'h4);
        chk("lmask", lint_maskable, 4'h4);
        @(posedge clk) begin
            mode_wr <= 1'h1;
            mode_wdata <= 8'h02;
        end
        @(posedge clk) mode_wr <= 1'h0;
        @(posedge clk) #1 chk("lnmi", lint_nmi, 4'h0);
    endtask
    // Wrong mode ignored, then back-to-back messages to two cores
    task t_ipi;
        @(posedge clk) begin
            clr <= 1'h0;
            ipi_valid <= 1'h1;
            ipi_mode <= 3'h4;
            ipi_dest <= 4'h2;
        end
        @(posedge clk) ipi_mode <= DELIV_RESET;
        #1 chk("cores", core_reset_out, 4'h0);
        @(posedge clk) ipi_dest <= 4'h8;
        #1 chk("cores", core_reset_out, 4'h2);
        @(posedge clk) ipi_valid <= 1'h0;
        #1 chk("cores", core_reset_out, 4'hA);
        @(posedge clk) #1 chk("cores", core_reset_out, 4'h8);
        @(posedge clk) #1 chk("cores", core_reset_out, 4'h0);
        @(posedge clk) #1 chk("restart", restarted, 4'hA);
    endtask
    // Port write waits for a boundary; shutdown cycle after the pulse
    task t_soft;
        @(posedge clk) begin
            reset_port_wr <= 1'h1;
            mode_wr <= 1'h1;
            mode_wdata <= MODE_SEL_THRU;
        end
        @(posedge clk) begin
            reset_port_wr <= 1'h0;
            mode_wr <= 1'h0;
        end
        repeat (3) @(posedge clk);
        #1 chk("soft", soft_init, 4'h0);
        chk("mode", 4'(interrupt_mode_select_reg), 4'h1);
        @(posedge clk) cycle_boundary <= 1'h1;
        @(posedge clk) #1 chk("soft", soft_init, 4'hF);
        chk("mode", 4'(interrupt_mode_select_reg), 4'h0);
        @(posedge clk) #1 chk("soft", soft_init, 4'hF);
        @(posedge clk) shutdown_cycle <= 1'h1;
        #1 chk("soft", soft_init, 4'h0);
        @(posedge clk) shutdown_cycle <= 1'h0;
        @(posedge clk) #1 chk("soft", soft_init, 4'hF);
    endtask
    // Panel reset mid-run acts with no clock edge
    task t_panel;
        @(posedge clk) panel_reset <= 1'h1;
        #1 chk("hard", 4'(hard_reset), 4'h1);
        chk("cores", core_reset_out, 4'hF);
        @(posedge clk) panel_reset <= 1'h0;
        repeat (5) @(posedge clk);
        #1 chk("hard", 4'(hard_reset), 4'h0);
        chk("units", unit_enable, 4'h4);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        repeat (5) @(posedge clk);
        #1 t_init;
        t_route;
        t_ipi;
        t_soft;
        t_panel;
        end_of_test;
    end
    // A hang counts as a mismatch
    initial begin
        #20000;
        miscompares++;
        end_of_test;
    end
endmodule
